// [rtl/srp_defs.svh]
// constants of the serial register port with read checksum
`ifndef SRP_DEFS_SVH
`define SRP_DEFS_SVH
`define SRP_CMD_BITS 5'd8
`define SRP_CMD_WR_BIT 7
`define SRP_ADDR_W 6
`define SRP_DATA_W 24
`define SRP_CHK_W 6
`define SRP_CHK_ADDR 6'h3E
`define SRP_CHK_BITS 5'd6
`define SRP_MAX_BITS 5'd24
`endif

// [rtl/srp_pkg.sv]
// types of the serial register port
package srp_pkg;
  typedef enum logic [1:0] {
    SRP_ST_IDLE = 2'b00,
    SRP_ST_CMD = 2'b01,
    SRP_ST_WDATA = 2'b10,
    SRP_ST_RDATA = 2'b11
  } srp_state_type;
endpackage

// [rtl/srp_port.sv]
// serial register port: command byte, register read/write, read checksum
`timescale 1ns/100ps
`default_nettype none
`include "srp_defs.svh"
// Operation
// - after reset, a chip select falling edge enters command mode.
// - each transfer starts with a command byte, first byte in command mode.
// - command is 8 bits; top bit selects direction, low 6 bits address.
// - transfer ends only after the register LSB crosses the link.
// - checksum is cleared before the first read data bit goes out.
// - each read bit driven on a rising edge is added to the checksum.
// - reading the checksum register recomputes checksum over that read.
// - link timing depends only on the serial clock, not master clock; here sclk, din and cs_n are sampled on ref_clk.
// - top command bit 1 means write, 0 means read.
// - input sampled on falling edges, output changed on rising edges.
// - chip select rising mid-transfer aborts and floats serial output.
// - data moves MSB byte first, right justified, unused upper bits ignored.
module srp_port
  import srp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic din,
  input wire logic cs_n,
  output logic dout,
  output logic dout_oe,
  output logic [5:0] reg_addr,
  input wire logic [4:0] reg_bits,
  input wire logic [23:0] reg_rd_data,
  output logic reg_rd_stb,
  output logic reg_wr_stb,
  output logic [7:0] reg_wr_byte,
  output logic [1:0] reg_wr_idx,
  output logic [5:0] chk_value
);
  logic sclk_s1, sclk_s2, sclk_s3;
  logic din_s1, din_s2;
  logic cs_s1, cs_s2, cs_s3;
  logic sclk_rise, sclk_fall, cs_rise, cs_fall;
  srp_state_type state_r;
  logic [4:0] cnt_r;
  logic [7:0] cmd_sh_r;
  logic cmd_done;
  logic ld_r;
  logic wr_dir_r;
  logic [4:0] tot_r;
  logic [4:0] bits_eff;
  logic [1:0] nbytes;
  logic [23:0] rd_sh_r;
  logic [7:0] wsh_r;
  logic [7:0] wbyte_nxt;
  logic [7:0] wmask;
  logic [5:0] chk_r;
  logic dout_r, oe_r;
  logic wr_stb_r;
  logic [7:0] wr_byte_r;
  logic [1:0] wr_idx_r;
  logic [5:0] addr_r;
  logic rd_done;

  // sclk, din and cs_n cross into ref_clk; link timing rides on sclk edges only
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_s1 <= 1'b1;
      sclk_s2 <= 1'b1;
      sclk_s3 <= 1'b1;
      din_s1 <= 1'b0;
      din_s2 <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
    end else begin
      sclk_s1 <= sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      din_s1 <= din;
      din_s2 <= din_s1;
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
    end
  end

  // sclk is ignored while deselected, so clock noise on a shared bus is safe
  assign sclk_rise = sclk_s2 & ~sclk_s3 & ~cs_s2;
  assign sclk_fall = ~sclk_s2 & sclk_s3 & ~cs_s2;
  assign cs_rise = cs_s2 & ~cs_s3;
  // sync flops reset high: a chip select tied low still yields one fall
  assign cs_fall = ~cs_s2 & cs_s3;

  assign cmd_done = (state_r == SRP_ST_CMD) && sclk_fall &&
                    (cnt_r == `SRP_CMD_BITS - 5'd1);
  assign rd_done = (state_r == SRP_ST_RDATA) && sclk_fall && (cnt_r == tot_r);

  // byte count from the addressed register width; checksum is one byte
  assign bits_eff = (addr_r == `SRP_CHK_ADDR) ? `SRP_CHK_BITS :
                    (reg_bits == 5'd0) ? `SRP_MAX_BITS : reg_bits;
  assign nbytes = 2'((bits_eff + 5'd7) >> 3);
  assign wmask = (bits_eff[2:0] == 3'd0) ? 8'hFF :
                 ~(8'hFF << bits_eff[2:0]);
  assign wbyte_nxt = {wsh_r[6:0], din_s2};

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= SRP_ST_IDLE;
    end else if (cs_rise) begin
      state_r <= SRP_ST_IDLE;
    end else if (cs_fall) begin
      state_r <= SRP_ST_CMD;
    end else if (cmd_done) begin
      // first byte in command mode is always the command
      if (cmd_sh_r[6] == 1'b1) begin
        state_r <= SRP_ST_WDATA;
      end else begin
        state_r <= SRP_ST_RDATA;
      end
    end else if (rd_done) begin
      state_r <= SRP_ST_CMD;
    end else if (state_r == SRP_ST_WDATA && sclk_fall &&
                 cnt_r == tot_r - 5'd1) begin
      state_r <= SRP_ST_CMD;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 5'd0;
      cmd_sh_r <= 8'h00;
      addr_r <= 6'h00;
      wr_dir_r <= 1'b0;
      ld_r <= 1'b0;
    end else begin
      ld_r <= cmd_done;
      if (cs_rise || cs_fall || cmd_done || rd_done) begin
        cnt_r <= 5'd0;
      end else if (state_r == SRP_ST_WDATA && sclk_fall &&
                   cnt_r == tot_r - 5'd1) begin
        cnt_r <= 5'd0;
      end else if ((state_r == SRP_ST_RDATA && sclk_rise) ||
                   ((state_r == SRP_ST_CMD || state_r == SRP_ST_WDATA) &&
                    sclk_fall)) begin
        cnt_r <= cnt_r + 5'd1;
      end
      if (state_r == SRP_ST_CMD && sclk_fall) begin
        cmd_sh_r <= {cmd_sh_r[6:0], din_s2};
      end
      if (cmd_done) begin
        addr_r <= {cmd_sh_r[4:0], din_s2};
        wr_dir_r <= cmd_sh_r[`SRP_CMD_WR_BIT - 1];
      end
    end
  end

  // read shifter: whole register snapshot, left aligned, MSB first
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tot_r <= `SRP_MAX_BITS;
      rd_sh_r <= 24'h000000;
      dout_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      if (ld_r) begin
        tot_r <= {nbytes, 3'b000};
        if (addr_r == `SRP_CHK_ADDR) begin
          // snapshot taken before the clear, then recounted
          rd_sh_r <= {chk_r, 2'b00, 16'h0000} >> 2;
        end else begin
          rd_sh_r <= reg_rd_data << (`SRP_MAX_BITS - {nbytes, 3'b000});
        end
      end else if (state_r == SRP_ST_RDATA && sclk_rise) begin
        rd_sh_r <= {rd_sh_r[22:0], 1'b0};
      end
      if (state_r == SRP_ST_RDATA && sclk_rise) begin
        dout_r <= rd_sh_r[23];
        oe_r <= 1'b1;
      end
      if (cs_rise || rd_done || state_r != SRP_ST_RDATA) begin
        oe_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      chk_r <= 6'h00;
    end else if (ld_r && !wr_dir_r) begin
      chk_r <= 6'h00;
    end else if (state_r == SRP_ST_RDATA && sclk_rise) begin
      chk_r <= chk_r + {5'd0, rd_sh_r[23]};
    end
  end

  // a byte cut short by chip select never reaches the register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wsh_r <= 8'h00;
      wr_stb_r <= 1'b0;
      wr_byte_r <= 8'h00;
      wr_idx_r <= 2'd0;
    end else begin
      wr_stb_r <= 1'b0;
      if (state_r == SRP_ST_WDATA && sclk_fall && !cs_rise) begin
        wsh_r <= wbyte_nxt;
        if (cnt_r[2:0] == 3'd7) begin
          wr_stb_r <= 1'b1;
          wr_idx_r <= cnt_r[4:3];
          if (cnt_r[4:3] == 2'd0) begin
            wr_byte_r <= wbyte_nxt & wmask;
          end else begin
            wr_byte_r <= wbyte_nxt;
          end
        end
      end
    end
  end

  assign dout = dout_r;
  assign dout_oe = oe_r;
  assign reg_addr = addr_r;
  assign reg_rd_stb = ld_r & ~wr_dir_r;
  assign reg_wr_stb = wr_stb_r;
  assign reg_wr_byte = wr_byte_r;
  assign reg_wr_idx = wr_idx_r;
  assign chk_value = chk_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_oe_only_read: assert property (state_r != SRP_ST_RDATA |-> !oe_r)
    else $error("serial output driven outside read data");
  a_cs_abort: assert property (cs_rise |=> !oe_r && state_r == SRP_ST_IDLE)
    else $error("chip select rise did not abort");
  a_cmd_enter: assert property (cs_fall && !cs_rise |=> state_r == SRP_ST_CMD)
    else $error("chip select fall did not enter command mode");
  a_cmd_decode: assert property (cmd_done |=>
      addr_r == $past({cmd_sh_r[4:0], din_s2}) &&
      wr_dir_r == $past(cmd_sh_r[6]))
    else $error("command byte decoded wrongly");
  a_chk_clear: assert property (cmd_done && !cmd_sh_r[6] |=> ##1 chk_r == 6'h00)
    else $error("checksum not cleared before read data");
  a_chk_add: assert property (state_r == SRP_ST_RDATA && sclk_rise && !ld_r |=>
      chk_r == $past(chk_r) + {5'd0, $past(rd_sh_r[23])})
    else $error("checksum did not count a read bit");
  a_dout_rise: assert property (state_r == SRP_ST_RDATA && sclk_rise |=>
      dout_r == $past(rd_sh_r[23]) && oe_r)
    else $error("read bit not driven on rising edge");
  a_read_end: assert property (rd_done && !cs_rise |=>
      state_r == SRP_ST_CMD && !oe_r ##1 !oe_r)
    else $error("read did not end after its last bit");
  a_wr_in_data: assert property (wr_stb_r |-> $past(state_r) == SRP_ST_WDATA)
    else $error("write byte strobe outside write data");

  c_read: cover property (rd_done);
  c_write_last: cover property (wr_stb_r && state_r == SRP_ST_CMD);
  c_abort_read: cover property (cs_rise && state_r == SRP_ST_RDATA);
  c_chk_read: cover property (ld_r && addr_r == `SRP_CHK_ADDR && !wr_dir_r);
endmodule
`default_nettype wire

// [tb/srp_host.sv]
// host side serial master model for the register port
`timescale 1ns/100ps
`default_nettype none
module srp_host (
  input wire logic ref_clk,
  input wire logic dout,
  input wire logic dout_oe,
  output logic sclk,
  output logic din,
  output logic cs_n
);
  int hp = 4;
  initial begin
    sclk = 1'h0;
    din = 1'h0;
    cs_n = 1'h1;
  end
  // clock stands low between frames
  task automatic shift(input int n, input logic [7:0] tx,
                       output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sclk <= 1'h1;
      din <= tx[i];
      repeat (hp) @(posedge ref_clk);
      sclk <= 1'h0;
      @(posedge ref_clk);
      // a floating line reads as the inverse, so a late drive shows up
      rx[i] = dout_oe ? dout : ~dout;
      repeat (hp - 1) @(posedge ref_clk);
    end
  endtask
  task automatic begin_frame();
    cs_n <= 1'h0;
    repeat (8) @(posedge ref_clk);
  endtask
  // 52 cycles is 2600 ns; chip select high well over 100 ns
  task automatic end_frame();
    repeat (2) @(posedge ref_clk);
    // released line shows the inverse, not a held value
    din <= ~din;
    cs_n <= 1'h1;
    repeat (52) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// [tb/srp_port_tb_top.sv]
// self-checking bench for the serial register port
`timescale 1ns/100ps
`default_nettype none
module srp_port_tb_top;
  logic ref_clk, rstn, sclk, din, cs_n, dout, dout_oe;
  logic reg_rd_stb, reg_wr_stb;
  logic [5:0] reg_addr, chk_value;
  logic [4:0] reg_bits = 5'h00;
  logic [23:0] reg_rd_data = 24'h000000;
  logic [23:0] rd;
  logic [7:0] reg_wr_byte;
  logic [1:0] reg_wr_idx;
  logic [9:0] wq[$];
  int rd_stbs = 0;
  logic [5:0] rd_addr = 6'h00;
  int miscompares = 0;
  int compares = 0;
  srp_port dut (.ref_clk(ref_clk), .rstn(rstn), .sclk(sclk), .din(din),
    .cs_n(cs_n), .dout(dout), .dout_oe(dout_oe), .reg_addr(reg_addr),
    .reg_bits(reg_bits), .reg_rd_data(reg_rd_data),
    .reg_rd_stb(reg_rd_stb), .reg_wr_stb(reg_wr_stb),
    .reg_wr_byte(reg_wr_byte), .reg_wr_idx(reg_wr_idx),
    .chk_value(chk_value));
  srp_host host (.ref_clk(ref_clk), .dout(dout), .dout_oe(dout_oe),
    .sclk(sclk), .din(din), .cs_n(cs_n));
  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (reg_wr_stb === 1'h1) begin
      wq.push_back({reg_wr_idx, reg_wr_byte});
    end
    if (reg_rd_stb === 1'h1) begin
      rd_stbs <= rd_stbs + 1;
      rd_addr <= reg_addr;
    end
  end
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic xfer(input logic [7:0] cmd, input int nb,
                      input logic [23:0] wd, output logic [23:0] rdv);
    logic [7:0] b;
    rdv = 24'h000000;
    host.begin_frame();
    host.shift(8, cmd, b);
    for (int k = nb - 1; k >= 0; k--) begin
      host.shift(8, wd[8*k +: 8], b);
      rdv[8*k +: 8] = b;
    end
    host.end_frame();
  endtask
  // first byte of a 12-bit register keeps only its low nibble
  task automatic t_write();
    reg_bits <= 5'h0C;
    xfer(8'h85, 2, 24'h00FA5C, rd);
    check(24'(reg_addr), 24'h000005);
    check(24'(wq.size()), 24'h000002);
    check(24'(wq[0]), 24'h00000A);
    check(24'(wq[1]), 24'h00015C);
  endtask
  // a stale count would carry over, so the second read proves the clear
  task automatic t_read(input logic [4:0] bits, input int hp, input int nb,
                        input logic [23:0] d, input logic [5:0] ones);
    int n0;
    reg_bits <= bits;
    reg_rd_data <= d;
    host.hp = hp;
    n0 = rd_stbs;
    xfer(8'h51, nb, 24'h000000, rd);
    check(24'(rd_stbs - n0), 24'h000001);
    check(24'(rd_addr), 24'h000011);
    check(rd, d);
    check(24'(chk_value), 24'(ones));
    check(24'(dout_oe), 24'h000000);
    check(24'(wq.size()), 24'h000002);
  endtask
  task automatic t_chk();
    reg_bits <= 5'h01;
    xfer(8'h3E, 1, 24'h000000, rd);
    check(rd, 24'h000007);
    check(24'(rd_addr), 24'h00003E);
    check(24'(chk_value), 24'h000003);
  endtask
  task automatic t_abort();
    logic [7:0] b;
    reg_bits <= 5'h00;
    reg_rd_data <= 24'hFFFFFF;
    host.begin_frame();
    host.shift(8, 8'h11, b);
    host.shift(4, 8'h00, b);
    check(24'(dout_oe), 24'h000001);
    host.end_frame();
    check(24'(dout_oe), 24'h000000);
    reg_bits <= 5'h08;
    xfer(8'h86, 1, 24'h000033, rd);
    check(24'(reg_addr), 24'h000006);
    check(24'(wq[$]), 24'h000033);
  endtask
  // reset pulse mid-run: checksum clears and a chip select fall resumes
  task automatic t_reset();
    rstn <= 1'h0;
    repeat (3) @(posedge ref_clk);
    check(24'(chk_value), 24'h000000);
    check(24'(dout_oe), 24'h000000);
    rstn <= 1'h1;
    repeat (5) @(posedge ref_clk);
    reg_bits <= 5'h08;
    xfer(8'h87, 1, 24'h0000C3, rd);
    check(24'(reg_addr), 24'h000007);
    check(24'(wq[$]), 24'h0000C3);
  endtask
  initial begin
    repeat (100000) @(posedge ref_clk);
    miscompares++;
    print_verdict();
  end
  initial begin
    rstn = 1'h0;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'h1;
    repeat (5) @(posedge ref_clk);
    check(24'(chk_value), 24'h000000);
    t_write();
    t_read(5'h00, 4, 3, 24'hA53C0F, 6'h0C);
    t_read(5'h0C, 4, 2, 24'h000ABC, 6'h07);
    t_chk();
    t_abort();
    t_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
